// [hdl/lsi_consts.svh]
`ifndef LSI_CONSTS_SVH
`define LSI_CONSTS_SVH
// ***********************************************************
// bus address and register indices
// ***********************************************************
`define LSI_ADDR        7'h39
`define LSI_IX_PWR      8'h00
`define LSI_IX_CLR      8'h01
`define LSI_IX_PER      8'h02
`define LSI_IX_ISEL     8'h03
`define LSI_IX_LIM_LO   8'h04
`define LSI_IX_LIM_HI   8'h05
`define LSI_IX_CNT_LO   8'h06
`define LSI_IX_CNT_HI   8'h07
`define LSI_IX_ID_LO    8'h08
`define LSI_IX_ID_HI    8'h09
// ***********************************************************
// field codes and reset values
// ***********************************************************
`define LSI_PWR_DOWN    8'h00
`define LSI_PWR_ON      8'h08
`define LSI_PWR_TEST1   8'h09
`define LSI_PWR_TEST2   8'h0A
`define LSI_PWR_TEST3   8'h0B
`define LSI_CLR_GO      8'h10
`define LSI_CLR_RST     8'h00
`define LSI_PER_RST     8'h02
`define LSI_PER_MAX     8'h07
`define LSI_ISEL_RISE   8'h01
`define LSI_ISEL_FALL   8'h02
`define LSI_ISEL_OFF    8'h03
`define LSI_LIM_LO_RST  8'h00
`define LSI_LIM_HI_RST  8'h08
`define LSI_PAT2        16'h5555
`define LSI_PAT3        16'hAAAA
// arbitrary identity value
`define LSI_PART_ID     16'h4C53
// ***********************************************************
// timing
// ***********************************************************
`define LSI_CLK_HZ      64'd10000000
`define LSI_T0_MS       64'd800
`define LSI_T0_CYC      (`LSI_T0_MS * `LSI_CLK_HZ / 64'd1000)
`endif

// [hdl/lsi_pkg.sv]
package lsi_pkg;
  // ***********************************************************
  // transfer sequencing states
  // ***********************************************************
  typedef enum logic [2:0] {
    LSI_IDLE  = 3'b000,
    LSI_ADDR  = 3'b001,
    LSI_INDEX = 3'b010,
    LSI_WRITE = 3'b011,
    LSI_READ  = 3'b100
  } lsi_state_t;
endpackage : lsi_pkg

// [hdl/lsi_i2c_slave.sv]
`timescale 1ns/1ps
`include "lsi_consts.svh"
// Summary of operation
// - each measurement is an unsigned 16-bit converter count
// - interrupt output signals unaided once the count passes the limit
// - while powered on, measure continuously; latest count readable except under power codes 0x0A and 0x0B
// - power-down stops measuring, quiets interrupt, keeps registers, bus alive
// - slave supports single and block reads and writes
// - bytes are eight bits, msb first, each followed by acknowledge
// - start, address 0x39 plus direction; acknowledge on match
// - in a write the second byte loads the register pointer
// - each written data byte is stored, acknowledged, pointer advances
// - writes to read-only registers move the pointer, change nothing
// - read sends the pointed byte; each master ack sends the next
// - power register: 0x00 down, 0x08 on, on is default
// - power codes 0x0A and 0x0B read result as 0x5555 and 0xAAAA
// - writing 0x10 to clear register zeroes result, then self-clears
// - period codes 0..7 give 800 ms halving to 6.25 ms
// - 16-bit limit in two bytes, defaults high 0x08, low 0x00
// - 16-bit result read-only, low byte then high, default zero
// - fixed read-only 16-bit identity in two bytes
// - unlisted values to control registers store their default
// - interrupt select: 0x01 rise, 0x02 fall, 0x03 off held high
// - interrupt active after count above limit, until count at or below
module lsi_i2c_slave #(
  parameter int unsigned P_T0_CYC = 32'(`LSI_T0_CYC)
) (
  // system
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_clk_en,
  // serial link
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_o,
  output logic             o_sda_oe,
  // converter
  input  wire logic [15:0] i_light_sample,
  // interrupt pin
  output logic             o_irq
);
  import lsi_pkg::*;

  // ***********************************************************
  // pin synchronisers and start/stop detection
  // ***********************************************************
  logic [2:0] scl_s_r;
  logic [2:0] sda_s_r;
  logic       scl_st_r;
  logic       sda_st_r;
  logic       link_rst_r;

  wire scl_agree_w = (scl_s_r[1] == scl_s_r[2]);
  wire sda_agree_w = (sda_s_r[1] == sda_s_r[2]);
  wire scl_high_w  = scl_st_r && scl_agree_w && scl_s_r[2];
  wire start_w = scl_high_w && sda_st_r && sda_agree_w && !sda_s_r[2];
  wire stop_w  = scl_high_w && !sda_st_r && sda_agree_w && sda_s_r[2];

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      scl_s_r  <= 3'h7;
      sda_s_r  <= 3'h7;
      scl_st_r <= 1'b1;
      sda_st_r <= 1'b1;
    end else if (i_clk_en) begin
      scl_s_r <= {scl_s_r[1:0], i_scl};
      sda_s_r <= {sda_s_r[1:0], i_sda};
      if (scl_agree_w) begin
        scl_st_r <= scl_s_r[2];
      end
      if (sda_agree_w) begin
        sda_st_r <= sda_s_r[2];
      end
    end
  end

  // a start or stop re-arms the link side for a fresh frame
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      link_rst_r <= 1'b1;
    end else if (i_clk_en) begin
      link_rst_r <= start_w || stop_w;
    end
  end

  // ***********************************************************
  // link side, clocked by the bus clock
  // ***********************************************************
  logic [3:0] bit_cnt_r;
  logic [7:0] rx_sh_r;
  logic [7:0] tx_sh_r;
  logic [7:0] rx_byte_r;
  logic [7:0] tx_r;
  logic       first_r;
  logic       sel_r;
  logic       rd_r;
  logic       nack_r;
  logic       rx_tgl_r;
  logic       sda_oe_r;
  logic       sda_o_r;

  wire last_bit_w = (bit_cnt_r == 4'h7);
  wire ack_bit_w  = (bit_cnt_r == 4'h8);
  wire addr_hit_w = (rx_sh_r[6:0] == `LSI_ADDR);
  wire ack_due_w  = sel_r && (first_r || !rd_r);
  wire tx_on_w    = sel_r && rd_r && !first_r && !nack_r;

  always_ff @(posedge i_scl or posedge link_rst_r) begin
    if (link_rst_r) begin
      bit_cnt_r <= 4'h0;
      rx_sh_r   <= 8'h00;
      first_r   <= 1'b1;
      sel_r     <= 1'b0;
      rd_r      <= 1'b0;
      nack_r    <= 1'b0;
    end else begin
      bit_cnt_r <= ack_bit_w ? 4'h0 : bit_cnt_r + 4'h1;
      if (!ack_bit_w) begin
        rx_sh_r <= {rx_sh_r[6:0], i_sda};
      end
      if (last_bit_w && first_r) begin
        sel_r <= addr_hit_w;
        rd_r  <= i_sda;
      end
      if (ack_bit_w) begin
        first_r <= 1'b0;
      end
      if (ack_bit_w && tx_on_w && i_sda) begin
        nack_r <= 1'b1;
      end
    end
  end

  // byte hand-over: data held stable, event carried by a toggle
  always_ff @(posedge i_scl or posedge i_reset) begin
    if (i_reset) begin
      rx_tgl_r  <= 1'b0;
      rx_byte_r <= 8'h00;
    end else if (last_bit_w) begin
      rx_tgl_r  <= !rx_tgl_r;
      rx_byte_r <= {rx_sh_r[6:0], i_sda};
    end
  end

  // data line driven on the falling bus clock edge
  always_ff @(negedge i_scl or posedge link_rst_r) begin
    if (link_rst_r) begin
      sda_oe_r <= 1'b0;
      tx_sh_r  <= 8'h00;
      sda_o_r  <= 1'b0;
    end else if (ack_bit_w) begin
      sda_oe_r <= ack_due_w;
    end else if (tx_on_w) begin
      if (bit_cnt_r == 4'h0) begin
        tx_sh_r  <= {tx_r[6:0], 1'b0};
        sda_oe_r <= !tx_r[7];
      end else begin
        tx_sh_r  <= {tx_sh_r[6:0], 1'b0};
        sda_oe_r <= !tx_sh_r[7];
      end
    end else begin
      sda_oe_r <= 1'b0;
    end
  end

  assign o_sda_o  = sda_o_r;
  assign o_sda_oe = sda_oe_r;

  // ***********************************************************
  // byte event crossing into the system clock
  // ***********************************************************
  logic [2:0] tgl_s_r;

  wire byte_ev_w = tgl_s_r[1] ^ tgl_s_r[2];

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      tgl_s_r <= 3'h0;
    end else if (i_clk_en) begin
      tgl_s_r <= {tgl_s_r[1:0], rx_tgl_r};
    end
  end

  // ***********************************************************
  // register bank
  // ***********************************************************
  lsi_state_t  state_r;
  lsi_state_t  state_nxt;
  logic [7:0]  ptr_r;
  logic [7:0]  pwr_r;
  logic [7:0]  clr_r;
  logic [7:0]  per_r;
  logic [7:0]  isel_r;
  logic [7:0]  lim_lo_r;
  logic [7:0]  lim_hi_r;
  logic [15:0] count_r;
  logic [22:0] tim_r;
  logic        over_r;
  logic        irq_r;

  wire [15:0] limit_w = {lim_hi_r, lim_lo_r};
  wire [15:0] part_id_w = `LSI_PART_ID;
  wire        pwr_on_w = (pwr_r != `LSI_PWR_DOWN);
  wire [7:0]  b_w = rx_byte_r;
  wire        addr_ev_w = byte_ev_w && (state_r == LSI_ADDR);
  wire        match_w = (b_w[7:1] == `LSI_ADDR);
  wire        load_rd_w = addr_ev_w && match_w && b_w[0];
  wire        idx_ev_w = byte_ev_w && (state_r == LSI_INDEX);
  wire        wr_ev_w = byte_ev_w && (state_r == LSI_WRITE);
  wire        rd_ev_w = byte_ev_w && (state_r == LSI_READ);
  wire        clr_go_w = stop_w && (clr_r == `LSI_CLR_GO);

  // write qualification, unlisted values fall back to defaults
  wire pwr_ok_w = (b_w == `LSI_PWR_DOWN) || (b_w == `LSI_PWR_ON)
                  || (b_w == `LSI_PWR_TEST1) || (b_w == `LSI_PWR_TEST2)
                  || (b_w == `LSI_PWR_TEST3);
  wire per_ok_w  = (b_w <= `LSI_PER_MAX);
  wire isel_ok_w = (b_w >= `LSI_ISEL_RISE) && (b_w <= `LSI_ISEL_OFF);
  wire [7:0] pwr_wd_w  = pwr_ok_w ? b_w : `LSI_PWR_ON;
  wire [7:0] clr_wd_w  = (b_w == `LSI_CLR_GO) ? b_w : `LSI_CLR_RST;
  wire [7:0] per_wd_w  = per_ok_w ? b_w : `LSI_PER_RST;
  wire [7:0] isel_wd_w = isel_ok_w ? b_w : `LSI_ISEL_OFF;

  // result view, test codes 0x0A and 0x0B substitute fixed patterns
  wire [15:0] view_w = (pwr_r == `LSI_PWR_TEST2) ? `LSI_PAT2 :
                       (pwr_r == `LSI_PWR_TEST3) ? `LSI_PAT3 :
                       count_r;

  // read data for the byte about to be sent
  wire [7:0] rd_ix_w = load_rd_w ? ptr_r : ptr_r + 8'h01;
  wire [7:0] rd_data_w =
    (rd_ix_w == `LSI_IX_PWR)    ? pwr_r :
    (rd_ix_w == `LSI_IX_CLR)    ? clr_r :
    (rd_ix_w == `LSI_IX_PER)    ? per_r :
    (rd_ix_w == `LSI_IX_ISEL)   ? isel_r :
    (rd_ix_w == `LSI_IX_LIM_LO) ? lim_lo_r :
    (rd_ix_w == `LSI_IX_LIM_HI) ? lim_hi_r :
    (rd_ix_w == `LSI_IX_CNT_LO) ? view_w[7:0] :
    (rd_ix_w == `LSI_IX_CNT_HI) ? view_w[15:8] :
    (rd_ix_w == `LSI_IX_ID_LO)  ? part_id_w[7:0] :
    (rd_ix_w == `LSI_IX_ID_HI)  ? part_id_w[15:8] :
    8'h00;

  // transfer sequencing
  always_comb begin
    state_nxt = state_r;
    if (start_w || stop_w) begin
      state_nxt = start_w ? LSI_ADDR : LSI_IDLE;
    end else if (byte_ev_w) begin
      unique case (state_r)
        LSI_IDLE:  state_nxt = LSI_IDLE;
        LSI_ADDR: begin
          if (!match_w) begin
            state_nxt = LSI_IDLE;
          end else if (b_w[0]) begin
            state_nxt = LSI_READ;
          end else begin
            state_nxt = LSI_INDEX;
          end
        end
        LSI_INDEX: state_nxt = LSI_WRITE;
        LSI_WRITE: state_nxt = LSI_WRITE;
        LSI_READ:  state_nxt = LSI_READ;
        default:   state_nxt = LSI_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_r <= LSI_IDLE;
      ptr_r   <= 8'h00;
      tx_r    <= 8'h00;
    end else if (i_clk_en) begin
      state_r <= state_nxt;
      if (idx_ev_w) begin
        ptr_r <= b_w;
      end else if (wr_ev_w || rd_ev_w) begin
        ptr_r <= ptr_r + 8'h01;
      end
      if (load_rd_w || rd_ev_w) begin
        tx_r <= rd_data_w;
      end
    end
  end

  // control registers; read-only indices ignore writes
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pwr_r    <= `LSI_PWR_ON;
      clr_r    <= `LSI_CLR_RST;
      per_r    <= `LSI_PER_RST;
      isel_r   <= `LSI_ISEL_OFF;
      lim_lo_r <= `LSI_LIM_LO_RST;
      lim_hi_r <= `LSI_LIM_HI_RST;
    end else if (i_clk_en) begin
      if (wr_ev_w && ptr_r == `LSI_IX_PWR) begin
        pwr_r <= pwr_wd_w;
      end
      if (clr_go_w) begin
        clr_r <= `LSI_CLR_RST;
      end else if (wr_ev_w && ptr_r == `LSI_IX_CLR) begin
        clr_r <= clr_wd_w;
      end
      if (wr_ev_w && ptr_r == `LSI_IX_PER) begin
        per_r <= per_wd_w;
      end
      if (wr_ev_w && ptr_r == `LSI_IX_ISEL) begin
        isel_r <= isel_wd_w;
      end
      if (wr_ev_w && ptr_r == `LSI_IX_LIM_LO) begin
        lim_lo_r <= b_w;
      end
      if (wr_ev_w && ptr_r == `LSI_IX_LIM_HI) begin
        lim_hi_r <= b_w;
      end
    end
  end

  // ***********************************************************
  // measurement timing and interrupt
  // ***********************************************************
  wire [22:0] period_w = 23'(P_T0_CYC >> per_r[2:0]) - 23'h1;
  wire        meas_ev_w = pwr_on_w && (tim_r >= period_w);
  wire        above_w = (i_light_sample > limit_w);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      tim_r   <= 23'h0;
      count_r <= 16'h0000;
      over_r  <= 1'b0;
    end else if (i_clk_en) begin
      if (clr_go_w) begin
        tim_r   <= 23'h0;
        count_r <= 16'h0000;
      end else if (meas_ev_w) begin
        tim_r   <= 23'h0;
        count_r <= i_light_sample;
      end else if (pwr_on_w) begin
        tim_r <= tim_r + 23'h1;
      end
      if (!pwr_on_w) begin
        over_r <= 1'b0;
      end else if (meas_ev_w) begin
        over_r <= above_w;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_r <= 1'b1;
    end else if (i_clk_en) begin
      if (isel_r == `LSI_ISEL_RISE) begin
        irq_r <= over_r;
      end else if (isel_r == `LSI_ISEL_FALL) begin
        irq_r <= !over_r;
      end else begin
        irq_r <= 1'b1;
      end
    end
  end

  assign o_irq = irq_r;

  // ***********************************************************
  // assertions
  // ***********************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  pdown_quiet_a: assert property (
    (i_clk_en && !pwr_on_w && !clr_go_w)
    |=> (!over_r && $stable(tim_r) && $stable(count_r)))
    else $error("power-down did not stop measuring");
  irq_off_a: assert property (
    (i_clk_en && isel_r == `LSI_ISEL_OFF) |=> o_irq)
    else $error("disabled interrupt not held high");
  irq_fall_a: assert property (
    (i_clk_en && isel_r == `LSI_ISEL_FALL && over_r) |=> !o_irq)
    else $error("falling interrupt not low");
  irq_set_a: assert property (
    (i_clk_en && pwr_on_w && meas_ev_w && above_w) |=> over_r)
    else $error("count above limit did not raise interrupt");
  idx_load_a: assert property (
    (i_clk_en && idx_ev_w && !start_w && !stop_w)
    |=> (ptr_r == $past(b_w) && state_r == LSI_WRITE))
    else $error("index byte did not load pointer");
  ptr_step_a: assert property (
    (i_clk_en && wr_ev_w) |=> (ptr_r == 8'($past(ptr_r) + 8'h01)))
    else $error("pointer did not advance after write");
  ro_keep_a: assert property (
    (i_clk_en && wr_ev_w && ptr_r == `LSI_IX_CNT_LO && !meas_ev_w
     && !clr_go_w) |=> $stable(count_r))
    else $error("read-only result was overwritten");
  bad_per_a: assert property (
    (i_clk_en && wr_ev_w && ptr_r == `LSI_IX_PER && !per_ok_w)
    |=> per_r == `LSI_PER_RST)
    else $error("bad period code not replaced by default");
  soft_clr_a: assert property (
    (i_clk_en && clr_go_w) |=> (count_r == 16'h0000 && clr_r == 8'h00))
    else $error("clear command did not zero result");

  read_cov: cover property (i_clk_en && load_rd_w);
  write_cov: cover property (i_clk_en && wr_ev_w ##[1:300] stop_w);
  clear_cov: cover property (i_clk_en && clr_go_w);
  irq_cov: cover property (!over_r ##1 over_r);
endmodule : lsi_i2c_slave

// [verif/lsi_i2c_master.sv]
`timescale 1ns/1ps
module lsi_i2c_master (
  // system
  input  wire logic i_clk,
  // bus pins
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_pull
);
  // ***********************************************************
  // bus idles high, clock stands still between frames
  // ***********************************************************
  initial begin
    o_scl      = 1'b1;
    o_sda_pull = 1'b0;
  end
  // quarter of a 4 us bit period
  task automatic q();
    repeat (10) @(posedge i_clk);
  endtask : q
  // also serves as repeated start
  task automatic start();
    q();
    o_sda_pull <= 1'b0;
    q();
    o_scl <= 1'b1;
    q();
    o_sda_pull <= 1'b1;
    q();
    o_scl <= 1'b0;
  endtask : start
  task automatic stop();
    q();
    o_sda_pull <= 1'b1;
    q();
    o_scl <= 1'b1;
    q();
    o_sda_pull <= 1'b0;
    q();
  endtask : stop
  // data settles while clock is low, sampled mid high phase
  task automatic xbit(input logic b, output logic r);
    q();
    o_sda_pull <= ~b;
    q();
    o_scl <= 1'b1;
    q();
    r = i_sda;
    q();
    o_scl <= 1'b0;
  endtask : xbit
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r);
    end
    xbit(1'b1, r);
    ack = ~r;
  endtask : wbyte
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, d[i]);
    end
    xbit(~ack, r);
  endtask : rbyte
endmodule : lsi_i2c_master

// [verif/light_sensor_i2c_register_slave_tb.sv]
`timescale 1ns/1ps
`include "lsi_consts.svh"
module light_sensor_i2c_register_slave_tb;
  localparam int unsigned T0 = 800;
  localparam logic [15:0] ID = `LSI_PART_ID;
  logic        i_clk = 1'b0;
  logic        i_reset;
  logic        scl;
  logic        pull;
  logic        sda_o;
  logic        sda_oe;
  logic        irq;
  logic        ack;
  logic [15:0] sample;
  logic [7:0]  rb [0:15];
  int          mismatches = 0;
  int          tests_run = 0;
  wire         sda = ~(pull | (sda_oe & ~sda_o));
  logic [7:0]  dflt [0:10] = '{8'h08, 8'h00, 8'h02, 8'h03, 8'h00, 8'h08,
                               8'h00, 8'h00, ID[7:0], ID[15:8], 8'h00};
  logic [7:0]  bad [0:3] = '{8'h55, 8'h22, 8'h09, 8'h07};
  logic [7:0]  isel [0:4] = '{8'h01, 8'h02, 8'h02, 8'h01, 8'h03};
  logic [15:0] smp [0:4] = '{16'h2000, 16'h2000, 16'h1000, 16'h1000,
                             16'h1000};
  logic        irq_x [0:4] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  always #50 i_clk = ~i_clk;
  // ***********************************************************
  // design and bus master
  // ***********************************************************
  lsi_i2c_slave #(
    .P_T0_CYC (T0)
  ) dut_u (
    .i_clk          (i_clk),
    .i_reset        (i_reset),
    .i_clk_en       (1'b1),
    .i_scl          (scl),
    .i_sda          (sda),
    .o_sda_o        (sda_o),
    .o_sda_oe       (sda_oe),
    .i_light_sample (sample),
    .o_irq          (irq)
  );
  lsi_i2c_master m_u (
    .i_clk      (i_clk),
    .i_sda      (sda),
    .o_scl      (scl),
    .o_sda_pull (pull)
  );
  // ***********************************************************
  // access tasks
  // ***********************************************************
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  task automatic head(input logic [7:0] ix);
    m_u.start();
    m_u.wbyte(8'h72, ack);
    chk("address ack", 16'(ack), 16'h0001);
    m_u.wbyte(ix, ack);
    chk("index ack", 16'(ack), 16'h0001);
  endtask : head
  task automatic wr(input logic [7:0] ix, input logic [7:0] d [$]);
    head(ix);
    foreach (d[i]) begin
      m_u.wbyte(d[i], ack);
      chk("data ack", 16'(ack), 16'h0001);
    end
    m_u.stop();
  endtask : wr
  task automatic rd(input logic [7:0] ix, input int n);
    head(ix);
    m_u.start();
    m_u.wbyte(8'h73, ack);
    chk("read address ack", 16'(ack), 16'h0001);
    for (int i = 0; i < n; i++) begin
      m_u.rbyte(i < n - 1, rb[i]);
    end
    m_u.stop();
  endtask : rd
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  // ***********************************************************
  // test sequence
  // ***********************************************************
  initial begin
    // driven late in the first time step so every flop sees the edge
    i_reset <= 1'b1;
    sample <= 16'h0000;
    tick(2);
    i_reset <= 1'b0;
    tick(10);
    rd(8'h00, 11);
    foreach (dflt[i]) begin
      chk("reset value", 16'(rb[i]), 16'(dflt[i]));
    end
    m_u.start();
    m_u.wbyte(8'h74, ack);
    chk("foreign address ack", 16'(ack), 16'h0000);
    m_u.stop();
    $display("test defaults done");
    sample <= 16'h1234;
    wr(8'h02, '{8'h07});
    tick(30);
    wr(8'h04, '{8'h00, 8'h10, 8'h99, 8'h99, 8'h99, 8'h99, 8'h99});
    wr(8'h06, '{8'h00});
    rd(8'h04, 4);
    chk("limit", {rb[1], rb[0]}, 16'h1000);
    chk("count", {rb[3], rb[2]}, 16'h1234);
    $display("test block access done");
    for (int i = 0; i < 4; i++) begin
      wr(8'(i), '{bad[i]});
      rd(8'(i), 1);
      chk("unlisted value", 16'(rb[0]), 16'(dflt[i]));
    end
    wr(8'h02, '{8'h07});
    $display("test unlisted values done");
    wr(8'h00, '{8'h09});
    rd(8'h00, 1);
    chk("reserved power code", 16'(rb[0]), 16'h0009);
    wr(8'h00, '{8'h0A});
    rd(8'h06, 2);
    chk("pattern 2", {rb[1], rb[0]}, 16'h5555);
    wr(8'h00, '{8'h0B});
    rd(8'h06, 2);
    chk("pattern 3", {rb[1], rb[0]}, 16'hAAAA);
    wr(8'h00, '{8'h08});
    $display("test patterns done");
    foreach (isel[i]) begin
      sample <= smp[i];
      wr(8'h03, '{isel[i]});
      tick(20);
      chk("irq level", 16'(irq), 16'(irq_x[i]));
    end
    sample <= 16'h2000;
    wr(8'h03, '{8'h01});
    tick(20);
    wr(8'h00, '{8'h00});
    tick(20);
    chk("irq in power-down", 16'(irq), 16'h0000);
    sample <= 16'h0777;
    tick(40);
    rd(8'h06, 2);
    chk("count held", {rb[1], rb[0]}, 16'h2000);
    $display("test interrupt done");
    wr(8'h01, '{8'h10});
    rd(8'h01, 1);
    chk("clear self-resets", 16'(rb[0]), 16'h0000);
    rd(8'h06, 2);
    chk("count cleared", {rb[1], rb[0]}, 16'h0000);
    wr(8'h00, '{8'h08});
    tick(30);
    rd(8'h04, 4);
    chk("limit kept", {rb[1], rb[0]}, 16'h1000);
    chk("count resumes", {rb[3], rb[2]}, 16'h0777);
    $display("test power and clear done");
    wrap_up();
  end
  // tests need about 55k cycles; give them some margin
  initial begin
    repeat (70000) @(posedge i_clk);
    mismatches++;
    wrap_up();
  end
endmodule : light_sensor_i2c_register_slave_tb
